// >>> vdwl_pkg.sv
package vdwl_pkg;
	// ------------------------------------------------------------
	// Bus address, word layout and timing
	// ------------------------------------------------------------
	localparam logic [4:0] DEV_ADDR_HI = 5'h03;
	localparam int ADDR_HI_LSB = 2;
	localparam int PD_BIT = 15;
	localparam int CODE_MSB_BIT = 13;
	localparam int CODE_LSB_BIT = 4;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [9:0] CODE_RESET = 10'h000;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam int CLK_HZ = 20000000;
	localparam int BUS_MAX_HZ = 400000;
	localparam int SCL_PERIOD_CYC = CLK_HZ / BUS_MAX_HZ;

	typedef enum logic [2:0]
	{
		VDWL_IDLE = 3'b000,
		VDWL_ADDR = 3'b001,
		VDWL_WDATA = 3'b010,
		VDWL_RDATA = 3'b011,
		VDWL_IGNORE = 3'b100
	} vdwl_state_type;

	typedef struct packed
	{
		logic power_down_flag;
		logic [9:0] code;
	} vdwl_dac_type;
endpackage : vdwl_pkg

// >>> vdwl_sync.sv
`timescale 1ns/10ps
module vdwl_sync
(
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic d,
	output logic q
);
	logic s1_r;

	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			s1_r <= 1'b1;
			q <= 1'b1;
		end
		else
		begin
			s1_r <= d;
			q <= s1_r;
		end
	end
endmodule : vdwl_sync

// >>> vdwl_loader.sv
`timescale 1ns/10ps
module vdwl_loader
(
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	output logic POWER_DOWN,
	output logic [9:0] DAC_CODE
);
	// ------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ------------------------------------------------------------
	// Sampling at 20 MHz leaves ample margin for a 400 kHz bus
	logic scl_s;
	logic sda_s;
	logic scl_d_r;
	logic sda_d_r;

	vdwl_sync u_scl (.CLK(CLK), .RESETN(RESETN), .d(SCL_IN), .q(scl_s));
	vdwl_sync u_sda (.CLK(CLK), .RESETN(RESETN), .d(SDA_IN), .q(sda_s));

	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end
		else
		begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
		end
	end

	wire scl_rise = scl_s & ~scl_d_r;
	wire scl_fall = ~scl_s & scl_d_r;
	wire start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
	wire stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;

	// ------------------------------------------------------------
	// Protocol state
	// ------------------------------------------------------------
	vdwl_pkg::vdwl_state_type state_r;
	vdwl_pkg::vdwl_state_type state_nxt;
	logic [3:0] bit_r;
	logic [7:0] sh_r;
	logic byte_idx_r;
	logic [15:0] word_r;
	logic [15:0] word_nxt;
	logic ack_r;
	logic read_done_r;
	vdwl_pkg::vdwl_dac_type dac_r;
	vdwl_pkg::vdwl_dac_type dac_nxt;
	logic sda_drv_r;

	function automatic vdwl_pkg::vdwl_dac_type word_to_dac(input logic [15:0] w);
		vdwl_pkg::vdwl_dac_type d;
		d.power_down_flag = w[vdwl_pkg::PD_BIT];
		d.code = w[vdwl_pkg::CODE_MSB_BIT:vdwl_pkg::CODE_LSB_BIT];
		return d;
	endfunction : word_to_dac

	wire [7:0] rx_byte = {sh_r[6:0], sda_s};
	wire byte_end = scl_rise && (bit_r == vdwl_pkg::BIT_LAST);
	wire addr_match = rx_byte[7:vdwl_pkg::ADDR_HI_LSB + 1] == vdwl_pkg::DEV_ADDR_HI;
	wire [7:0] tx_byte = byte_idx_r ? word_r[7:0] : word_r[15:8];
	wire last_byte = byte_idx_r;

	// Next state on a received byte boundary
	always_comb
	begin
		state_nxt = state_r;
		if (byte_end)
		begin
			unique case (state_r)
				vdwl_pkg::VDWL_IDLE: state_nxt = vdwl_pkg::VDWL_IGNORE;
				vdwl_pkg::VDWL_ADDR:
					state_nxt = !addr_match ? vdwl_pkg::VDWL_IGNORE :
						(rx_byte[0] ? vdwl_pkg::VDWL_RDATA : vdwl_pkg::VDWL_WDATA);
				vdwl_pkg::VDWL_WDATA: state_nxt = vdwl_pkg::VDWL_WDATA;
				vdwl_pkg::VDWL_RDATA: state_nxt = vdwl_pkg::VDWL_RDATA;
				vdwl_pkg::VDWL_IGNORE: state_nxt = vdwl_pkg::VDWL_IGNORE;
				default: state_nxt = vdwl_pkg::VDWL_IDLE;
			endcase
		end
	end

	// Input word: shift-in on writes, clear after a finished read
	always_comb
	begin
		word_nxt = word_r;
		if (stop_det && read_done_r)
			word_nxt = vdwl_pkg::WORD_RESET;
		else if (byte_end && state_r == vdwl_pkg::VDWL_WDATA && !ack_r)
		begin
			if (last_byte)
				word_nxt[7:0] = rx_byte;
			else
				word_nxt[15:8] = rx_byte;
		end
	end

	// Copy to holding register only once the low byte has landed
	always_comb
	begin
		dac_nxt = dac_r;
		if (byte_end && state_r == vdwl_pkg::VDWL_WDATA && last_byte)
			dac_nxt = word_to_dac({word_r[15:8], rx_byte});
	end

	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			state_r <= vdwl_pkg::VDWL_IDLE;
			bit_r <= 4'h0;
			sh_r <= 8'h00;
			byte_idx_r <= 1'b0;
			ack_r <= 1'b0;
			read_done_r <= 1'b0;
		end
		else if (start_det)
		begin
			state_r <= vdwl_pkg::VDWL_ADDR;
			bit_r <= 4'h0;
			byte_idx_r <= 1'b0;
			ack_r <= 1'b0;
			read_done_r <= 1'b0;
		end
		else if (stop_det)
		begin
			state_r <= vdwl_pkg::VDWL_IDLE;
			read_done_r <= 1'b0;
		end
		else if (scl_rise)
		begin
			state_r <= state_nxt;
			sh_r <= rx_byte;
			if (bit_r == vdwl_pkg::BIT_ACK)
			begin
				bit_r <= 4'h0;
				if (ack_r)
					ack_r <= 1'b0;
				else if (state_r == vdwl_pkg::VDWL_WDATA || state_r == vdwl_pkg::VDWL_RDATA)
					byte_idx_r <= ~byte_idx_r;
				if (state_r == vdwl_pkg::VDWL_RDATA && last_byte)
					read_done_r <= 1'b1;
			end
			else
			begin
				bit_r <= bit_r + 4'h1;
				if (byte_end)
					ack_r <= (state_r == vdwl_pkg::VDWL_ADDR) && addr_match;
			end
		end
	end

	// ------------------------------------------------------------
	// Data line drive, changed only while SCL is low
	// ------------------------------------------------------------
	// On a read the master answers the data bytes, so only the address byte and written bytes are acknowledged here
	wire in_ack = bit_r == vdwl_pkg::BIT_ACK;
	wire ack_slot = in_ack && (ack_r || state_r == vdwl_pkg::VDWL_WDATA);

	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
			sda_drv_r <= 1'b0;
		else if (start_det || stop_det)
			sda_drv_r <= 1'b0;
		else if (scl_fall)
		begin
			if (ack_slot)
				sda_drv_r <= 1'b1;
			// Let go once both bytes are out, else a low bit would block the stop
			else if (state_r == vdwl_pkg::VDWL_RDATA && !in_ack && !ack_r && !read_done_r)
				sda_drv_r <= ~tx_byte[3'(vdwl_pkg::BIT_LAST - bit_r)];
			else if (state_r == vdwl_pkg::VDWL_RDATA && ack_r && in_ack == 1'b0)
				sda_drv_r <= ~word_r[15];
			else
				sda_drv_r <= 1'b0;
		end
	end

	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			word_r <= vdwl_pkg::WORD_RESET;
			dac_r <= '{power_down_flag: 1'b0, code: vdwl_pkg::CODE_RESET};
		end
		else
		begin
			word_r <= word_nxt;
			dac_r <= dac_nxt;
		end
	end

	// Open drain: the pin only ever pulls low
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			SDA_OUT <= 1'b0;
			SDA_OE <= 1'b0;
			POWER_DOWN <= 1'b0;
			DAC_CODE <= vdwl_pkg::CODE_RESET;
		end
		else
		begin
			SDA_OUT <= 1'b0;
			SDA_OE <= sda_drv_r;
			POWER_DOWN <= dac_r.power_down_flag;
			DAC_CODE <= dac_r.code;
		end
	end
endmodule : vdwl_loader

// >>> vdwl_props.sv
`timescale 1ns/10ps
module vdwl_props
(
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	input wire logic SDA_OUT,
	input wire logic SDA_OE,
	input wire logic POWER_DOWN,
	input wire logic [9:0] DAC_CODE
);
	// ----
	// Pin and load timing
	// ----
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESETN);
	a_pin_pulls_low: assert property (SDA_OE |-> SDA_OUT == 1'b0)
		else $error("sda driven high");
	a_oe_rise_low: assert property ($rose(SDA_OE) |-> !SCL_IN)
		else $error("oe rose with scl high");
	a_oe_steady_high: assert property (SCL_IN && $past(SCL_IN) |-> $stable(SDA_OE))
		else $error("oe moved with scl high");
	// A read of zeros keeps the pin low for nine slots
	a_oe_released: assert property ($rose(SDA_OE) |-> ##[1:500] !SDA_OE)
		else $error("oe stuck");
	a_free_at_stop: assert property (SCL_IN && $rose(SDA_IN) |-> !SDA_OE)
		else $error("oe at stop");
	a_code_load_time: assert property ($changed(DAC_CODE) |-> SCL_IN)
		else $error("code moved off load");
	a_pd_load_time: assert property ($changed(POWER_DOWN) |-> SCL_IN)
		else $error("pd moved off load");
	a_idle_holds_dac: assert property ((SCL_IN && SDA_IN) [*8] |=> $stable(DAC_CODE))
		else $error("dac moved on idle bus");
	c_ack: cover property ($rose(SDA_OE));
	c_pd: cover property ($rose(POWER_DOWN));
	c_code: cover property ($changed(DAC_CODE));
endmodule : vdwl_props

// >>> vdwl_master.sv
`timescale 1ns/10ps
module vdwl_master
(
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_low
);
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// Period of 50 cycles keeps the bus at exactly 400 kHz
	task automatic bitx(input logic b, output logic r);
		@(posedge clk);
		sda_low <= !b;
		repeat (24) @(posedge clk);
		scl <= 1'b1;
		repeat (12) @(posedge clk);
		r = sda;
		repeat (13) @(posedge clk);
		scl <= 1'b0;
	endtask : bitx
	task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q, output logic k);
		for (int i = 7; i >= 0; i--)
			bitx(d[i], q[i]);
		bitx(mack, k);
	endtask : xfer
	task automatic start;
		@(posedge clk);
		sda_low <= 1'b1;
		repeat (25) @(posedge clk);
		scl <= 1'b0;
	endtask : start
	task automatic stop;
		@(posedge clk);
		sda_low <= 1'b1;
		repeat (24) @(posedge clk);
		scl <= 1'b1;
		repeat (25) @(posedge clk);
		sda_low <= 1'b0;
		repeat (25) @(posedge clk);
	endtask : stop
endmodule : vdwl_master

// >>> tb_top.sv
`timescale 1ns/10ps
module tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic scl, sda_low, sda_oe, sda_out, pd;
	logic [9:0] code;
	int err_total = 0;
	int check_count = 0;
	// Pull-up: the line is low while either side pulls it
	wire sda = !(sda_low || sda_oe);
	always #25 clk = ~clk;
	vdwl_loader u_dut (.CLK(clk), .RESETN(rst_n), .SCL_IN(scl), .SDA_IN(sda),
		.SDA_OUT(sda_out), .SDA_OE(sda_oe), .POWER_DOWN(pd), .DAC_CODE(code));
	vdwl_master u_mst (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] %s exp %h got %h", what, exp, got);
		end
	endtask : chk
	task automatic dac(input logic [15:0] w);
		chk("pd", {15'h0, w[15]}, {15'h0, pd});
		chk("code", {6'h0, w[13:4]}, {6'h0, code});
	endtask : dac
	task automatic wr(input logic [7:0] a, input logic [15:0] w, input int n);
		logic [7:0] q;
		logic k;
		u_mst.start();
		u_mst.xfer(a, 1'b1, q, k);
		chk("addr ack", {15'h0, a[7:3] != vdwl_pkg::DEV_ADDR_HI}, {15'h0, k});
		for (int i = 0; i < n; i++)
		begin
			u_mst.xfer(w[15 - 8 * i -: 8], 1'b1, q, k);
			chk("data ack", 16'h0, {15'h0, k});
		end
		u_mst.stop();
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] w);
		logic [7:0] h, l;
		logic k;
		u_mst.start();
		u_mst.xfer(a, 1'b1, h, k);
		chk("addr ack", 16'h0, {15'h0, k});
		u_mst.xfer(8'hff, 1'b0, h, k);
		u_mst.xfer(8'hff, 1'b1, l, k);
		u_mst.stop();
		chk("read", w, {h, l});
	endtask : rd
	task automatic t_load;
		logic [15:0] words [4] = '{16'hd56f, 16'h2a90, 16'h7fff, 16'h800f};
		dac(16'h0000);
		for (int j = 0; j < 4; j++)
		begin
			wr(8'h18 + 8'(2 * j), words[j], 2);
			dac(words[j]);
		end
		$display("load done");
	endtask : t_load
	task automatic t_refuse;
		wr(8'h20, 16'h0, 0);
		wr(8'h1a, 16'h1230, 1);
		dac(16'h800f);
		$display("refuse done");
	endtask : t_refuse
	task automatic t_read;
		wr(8'h1c, 16'h4ab5, 2);
		dac(16'h4ab5);
		rd(8'h19, 16'h4ab5);
		rd(8'h1f, 16'h0000);
		$display("read done");
	endtask : t_read
	task automatic finish_test;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : finish_test
	initial
	begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_load();
		t_refuse();
		t_read();
		finish_test();
	end
endmodule : tb_top
bind vdwl_loader vdwl_props u_props (.CLK(CLK), .RESETN(RESETN), .SCL_IN(SCL_IN),
	.SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .POWER_DOWN(POWER_DOWN),
	.DAC_CODE(DAC_CODE));
